// ==== ddc_pkg.sv ====
/*
 * Constants for the down-converter NCO sync and decimation block.
 * Assumes one sample clock; registers sit on a plain strobe port.
 */
package ddc_pkg;

    typedef logic signed [19:0] ddc_coef_t;

    // Register map
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PHASE_BASE = 8'h20;
    localparam logic [7:0] FREQ_BASE  = 8'h40;

    // Control fields
    localparam int LINK_EN_BIT  = 0;
    localparam int LSYNC_EN_BIT = 1;
    localparam int ARM_BIT      = 2;
    localparam int ENC64_BIT    = 3;
    localparam int DECIM_LSB    = 4;
    localparam int SEL_A_LSB    = 8;
    localparam int SEL_B_LSB    = 10;

    // Status fields
    localparam int ST_LARM_BIT  = 0;
    localparam int ST_SARM_BIT  = 1;
    localparam int ST_RESYNC    = 2;
    localparam int ST_CGS_BIT   = 3;
    localparam int ST_CNT_LSB   = 8;

    // Decimation field codes
    localparam logic [2:0] DEC_BYPASS = 3'h0;
    localparam logic [2:0] DEC_32     = 3'h4;

    localparam logic [31:0] CTRL_RST = 32'h0000_0000;

    // Halfband stages, 7 to 55 taps, in order of operation
    localparam int NSTG = 5;
    localparam int KMAX = 14;
    localparam int SMP_W = 15;
    localparam int ACC_W = 48;
    localparam int KS [NSTG] = '{2, 2, 3, 4, 14};
    localparam int SCALE [NSTG] = '{5, 11, 14, 17, 19};
    localparam ddc_coef_t CTR [NSTG] = '{
        20'sd16, 20'sd1024, 20'sd8192, 20'sd65536, 20'sd262144};
    localparam ddc_coef_t COEF [NSTG][KMAX] = '{
        '{0: -20'sd1, 1: 20'sd9, default: 20'sd0},
        '{0: -20'sd65, 1: 20'sd577, default: 20'sd0},
        '{0: 20'sd109, 1: -20'sd837, 2: 20'sd4824, default: 20'sd0},
        '{0: -20'sd327, 1: 20'sd2231, 2: -20'sd8881, 3: 20'sd39742,
          default: 20'sd0},
        '{-20'sd37, 20'sd118, -20'sd291, 20'sd612, -20'sd1159,
          20'sd2031, -20'sd3356, 20'sd5308, -20'sd8140, 20'sd12284,
          -20'sd18628, 20'sd29455, -20'sd53191, 20'sd166059}};

endpackage

// ==== ddc_top.sv ====
/*
 * NCO phase offset, NCO resynchronisation and halfband decimation.
 * Assumes mixer samples and overrange flags on i_clk; the sync and
 * sysref pins are asynchronous and are synchronised here.
 */
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module ddc_top (
    input  wire logic               i_clk,
    input  wire logic               i_reset,
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_rd,
    output logic      [31:0]        o_rdata,
    input  wire logic               i_sync_n,
    input  wire logic               i_sysref,
    input  wire logic signed [14:0] i_mix_i,
    input  wire logic signed [14:0] i_mix_q,
    input  wire logic signed [11:0] i_real,
    input  wire logic               i_ovr_zero,
    input  wire logic               i_ovr_one,
    output logic      [31:0]        o_phase_a,
    output logic      [31:0]        o_phase_b,
    output logic                    o_sync_pulse,
    output logic                    o_cgs_active,
    output logic      [15:0]        o_data_i,
    output logic      [15:0]        o_data_q,
    output logic                    o_valid,
    output logic                    o_complex
);

    typedef enum logic [1:0] {
        LS_IDLE  = 2'b00,
        LS_ARMED = 2'b01
    } ddc_lstate_t;

    localparam int SW = ddc_pkg::SMP_W;
    localparam int AW = ddc_pkg::ACC_W;
    logic [31:0]        ctrl_q;
    logic               arm_q;
    logic               resync_q;
    logic [7:0]         sync_cnt_q;
    logic [15:0]        phase_q [8];
    logic [31:0]        freq_q [8];
    logic [31:0]        acc_q [8];
    logic [2:0]         sync_s_q;
    logic [2:0]         sysref_s_q;
    ddc_lstate_t        lstate_q;
    logic               link_evt;
    logic               sysref_evt;
    logic               sync_evt;
    logic               wr_ctrl;
    logic               wr_phase;
    logic               wr_freq;
    logic [2:0]         widx;
    logic [2:0]         decim;
    logic [2:0]         first_stg;
    logic               bypass;
    logic [1:0]         sel_a;
    logic [1:0]         sel_b;
    logic signed [SW-1:0] st_i [ddc_pkg::NSTG+1];
    logic signed [SW-1:0] st_q [ddc_pkg::NSTG+1];
    logic               st_v [ddc_pkg::NSTG+1];

    ////////////////////////////////////////////////////////////////////
    // Register port
    assign widx     = i_addr[4:2];
    assign wr_ctrl  = i_wr && i_addr == ddc_pkg::CTRL_OFS;
    assign wr_phase = i_wr && i_addr[7:5] == ddc_pkg::PHASE_BASE[7:5];
    assign wr_freq  = i_wr && i_addr[7:5] == ddc_pkg::FREQ_BASE[7:5];
    assign decim    = ctrl_q[ddc_pkg::DECIM_LSB +: 3];
    assign bypass   = decim == ddc_pkg::DEC_BYPASS
                   || decim > ddc_pkg::DEC_32;
    assign first_stg = ddc_pkg::DEC_32 - decim;
    assign sel_a    = ctrl_q[ddc_pkg::SEL_A_LSB +: 2];
    assign sel_b    = ctrl_q[ddc_pkg::SEL_B_LSB +: 2];

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_q <= ddc_pkg::CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= i_wdata;
        end
    end

    // Index 0-3 channel A, 4-7 channel B
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int k = 0; k < 8; k++) begin
                phase_q[k] <= 16'h0000;
                freq_q[k]  <= 32'h0000_0000;
            end
        end else begin
            if (wr_phase) begin
                phase_q[widx] <= i_wdata[15:0];
            end
            if (wr_freq) begin
                freq_q[widx] <= i_wdata;
            end
        end
    end

    // Frequency write leaves phase undefined until a resync
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            resync_q <= 1'b0;
        end else if (wr_freq) begin
            resync_q <= 1'b1;
        end else if (sync_evt) begin
            resync_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            o_rdata <= 32'h0000_0000;
            if (i_addr == ddc_pkg::CTRL_OFS) begin
                o_rdata <= ctrl_q;
                o_rdata[ddc_pkg::ARM_BIT] <= arm_q;
            end else if (i_addr == ddc_pkg::STATUS_OFS) begin
                o_rdata[ddc_pkg::ST_LARM_BIT] <= lstate_q == LS_ARMED;
                o_rdata[ddc_pkg::ST_SARM_BIT] <= arm_q;
                o_rdata[ddc_pkg::ST_RESYNC]   <= resync_q;
                o_rdata[ddc_pkg::ST_CGS_BIT]  <= o_cgs_active;
                o_rdata[ddc_pkg::ST_CNT_LSB +: 8] <= sync_cnt_q;
            end else if (i_addr[7:5] == ddc_pkg::PHASE_BASE[7:5]) begin
                o_rdata[15:0] <= phase_q[widx];
            end else if (i_addr[7:5] == ddc_pkg::FREQ_BASE[7:5]) begin
                o_rdata <= freq_q[widx];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and sync events
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync_s_q   <= 3'h7;
            sysref_s_q <= 3'h0;
        end else begin
            sync_s_q   <= {sync_s_q[1:0], i_sync_n};
            sysref_s_q <= {sysref_s_q[1:0], i_sysref};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            lstate_q <= LS_IDLE;
        end else if (!ctrl_q[ddc_pkg::LSYNC_EN_BIT]
                  || !ctrl_q[ddc_pkg::LINK_EN_BIT]) begin
            lstate_q <= LS_IDLE;
        end else begin
            unique case (lstate_q)
                LS_IDLE: begin
                    if (!sync_s_q[1]) begin
                        lstate_q <= LS_ARMED;
                    end
                end
                LS_ARMED: begin
                    if (sync_s_q[1]) begin
                        lstate_q <= LS_IDLE;
                    end
                end
                default: begin
                    lstate_q <= LS_IDLE;
                end
            endcase
        end
    end

    assign link_evt = lstate_q == LS_ARMED && sync_s_q[1]
                   && ctrl_q[ddc_pkg::LSYNC_EN_BIT]
                   && ctrl_q[ddc_pkg::LINK_EN_BIT];
    assign sysref_evt = arm_q && sysref_s_q[1] && !sysref_s_q[2];
    assign sync_evt = link_evt || sysref_evt;

    // Software arming wins over the clearing edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            arm_q <= 1'b0;
        end else if (wr_ctrl) begin
            arm_q <= i_wdata[ddc_pkg::ARM_BIT];
        end else if (sysref_evt) begin
            arm_q <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_sync_pulse <= 1'b0;
            o_cgs_active <= 1'b0;
            sync_cnt_q   <= 8'h00;
        end else begin
            o_sync_pulse <= sync_evt;
            o_cgs_active <= lstate_q == LS_ARMED && !sync_s_q[1]
                         && !ctrl_q[ddc_pkg::ENC64_BIT];
            if (sync_evt) begin
                sync_cnt_q <= sync_cnt_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Phase accumulators
    for (genvar k = 0; k < 8; k++) begin : g_acc
        always_ff @(posedge i_clk) begin
            if (i_reset || sync_evt) begin
                acc_q[k] <= 32'h0000_0000;
            end else begin
                acc_q[k] <= acc_q[k] + freq_q[k];
            end
        end
    end

    // Offset left-justified: one lsb is 2^-16 of a turn
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_phase_a <= 32'h0000_0000;
            o_phase_b <= 32'h0000_0000;
        end else begin
            o_phase_a <= acc_q[sel_a] + {phase_q[sel_a], 16'h0000};
            o_phase_b <= acc_q[{1'b1, sel_b}]
                       + {phase_q[{1'b1, sel_b}], 16'h0000};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Halfband decimation chain
    function automatic logic signed [SW-1:0] rnd_sat(
        input logic signed [AW-1:0] a,
        input int                   sh
    );
        logic signed [AW-1:0] t;
        logic signed [AW-1:0] f;
        logic signed [AW-1:0] h;
        t = a >>> sh;
        f = a - (t <<< sh);
        h = 48'sd1 <<< (sh - 1);
        if (f > h || (f == h && t[0])) begin
            t = t + 48'sd1;
        end
        if (t > 48'sd16383) begin
            return 15'sh3fff;
        end else if (t < -48'sd16384) begin
            return 15'sh4000;
        end
        return t[SW-1:0];
    endfunction

    assign st_i[0] = i_mix_i;
    assign st_q[0] = i_mix_q;
    assign st_v[0] = 1'b1;

    for (genvar s = 0; s < ddc_pkg::NSTG; s++) begin : g_stg
        localparam int K   = ddc_pkg::KS[s];
        localparam int L   = 4 * K - 1;
        logic signed [SW-1:0] dl_i [L];
        logic signed [SW-1:0] dl_q [L];
        logic signed [AW-1:0] sum_i;
        logic signed [AW-1:0] sum_q;
        logic                 vin;
        logic                 ph_q;
        logic                 due_q;
        logic signed [SW-1:0] y_i_q;
        logic signed [SW-1:0] y_q_q;
        logic                 y_v_q;

        assign vin = !bypass && s >= first_stg
                  && (s == first_stg ? 1'b1 : st_v[s]);

        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                for (int j = 0; j < L; j++) begin
                    dl_i[j] <= '0;
                    dl_q[j] <= '0;
                end
            end else if (vin) begin
                dl_i[0] <= s == first_stg ? i_mix_i : st_i[s];
                dl_q[0] <= s == first_stg ? i_mix_q : st_q[s];
                for (int j = 1; j < L; j++) begin
                    dl_i[j] <= dl_i[j-1];
                    dl_q[j] <= dl_q[j-1];
                end
            end
        end

        // Folded: mirrored taps summed before one multiply
        always_comb begin
            sum_i = AW'(ddc_pkg::CTR[s]) * AW'(dl_i[2*K-1]);
            sum_q = AW'(ddc_pkg::CTR[s]) * AW'(dl_q[2*K-1]);
            for (int j = 0; j < K; j++) begin
                sum_i = sum_i + AW'(ddc_pkg::COEF[s][j])
                      * (AW'(dl_i[2*j]) + AW'(dl_i[L-1-2*j]));
                sum_q = sum_q + AW'(ddc_pkg::COEF[s][j])
                      * (AW'(dl_q[2*j]) + AW'(dl_q[L-1-2*j]));
            end
        end

        // Every second input yields one output
        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                ph_q  <= 1'b0;
                due_q <= 1'b0;
                y_v_q <= 1'b0;
                y_i_q <= '0;
                y_q_q <= '0;
            end else begin
                if (vin) begin
                    ph_q <= !ph_q;
                end
                due_q <= vin && ph_q;
                y_v_q <= due_q;
                if (due_q) begin
                    y_i_q <= rnd_sat(sum_i, ddc_pkg::SCALE[s]);
                    y_q_q <= rnd_sat(sum_q, ddc_pkg::SCALE[s]);
                end
            end
        end

        assign st_i[s+1] = y_i_q;
        assign st_q[s+1] = y_q_q;
        assign st_v[s+1] = y_v_q;
    end

    ////////////////////////////////////////////////////////////////////
    // Output words
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_data_i  <= 16'h0000;
            o_data_q  <= 16'h0000;
            o_valid   <= 1'b0;
            o_complex <= 1'b0;
        end else if (bypass) begin
            o_data_i  <= {i_real, 4'h0};
            o_data_q  <= 16'h0000;
            o_valid   <= 1'b1;
            o_complex <= 1'b0;
        end else begin
            o_valid   <= st_v[ddc_pkg::NSTG];
            o_complex <= 1'b1;
            if (st_v[ddc_pkg::NSTG]) begin
                o_data_i <= {st_i[ddc_pkg::NSTG], i_ovr_zero};
                o_data_q <= {st_q[ddc_pkg::NSTG], i_ovr_one};
            end
        end
    end

endmodule

// ==== ddc_sva.sv ====
/*
 * Port assertions for ddc_top: reset, bypass, decimation, sync.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns
module ddc_sva (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_rd,
    input wire logic        i_sync_n,
    input wire logic [31:0] o_rdata,
    input wire logic [31:0] o_phase_a,
    input wire logic [31:0] o_phase_b,
    input wire logic        o_sync_pulse,
    input wire logic        o_cgs_active,
    input wire logic [15:0] o_data_i,
    input wire logic [15:0] o_data_q,
    input wire logic        o_valid,
    input wire logic        o_complex
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////
    sequence quiet3;
        (!o_valid || !o_complex) [*3];
    endsequence
    sequence phase_home;
        ##[0:2] (o_phase_a[15:0] == 16'h0000 && o_phase_b[15:0] == 16'h0000);
    endsequence
    out_clear_a: assert property ($past(i_reset) |-> !o_sync_pulse
        && !o_cgs_active && o_phase_a == 32'h0000_0000)
        else $error("outputs not clear after reset");
    bypass_valid_a: assert property (
        !o_complex && !$past(o_complex) && !$past(i_reset) |-> o_valid)
        else $error("bypass output not valid every cycle");
    bypass_form_a: assert property (
        o_valid && !o_complex |-> o_data_q == 16'h0000
        && o_data_i[3:0] == 4'h0) else $error("bypass word malformed");
    decim_gap_a: assert property (
        o_valid && o_complex |=> quiet3)
        else $error("decimated samples too close");
    pulse_single_a: assert property (
        o_sync_pulse |=> !o_sync_pulse) else $error("sync pulse too long");
    phase_home_a: assert property (
        o_sync_pulse |-> phase_home) else $error("accumulators not cleared");
    rdata_hold_a: assert property (!$past(i_rd) |-> $stable(o_rdata))
        else $error("read data changed without read");
    cgs_start_a: assert property (
        $rose(o_cgs_active) |-> !$past(i_sync_n, 2))
        else $error("code group sync without sync low");
endmodule
bind ddc_top ddc_sva u_sva (
    .i_clk(i_clk), .i_reset(i_reset), .i_rd(i_rd), .i_sync_n(i_sync_n),
    .o_rdata(o_rdata), .o_phase_a(o_phase_a), .o_phase_b(o_phase_b),
    .o_sync_pulse(o_sync_pulse), .o_cgs_active(o_cgs_active),
    .o_data_i(o_data_i), .o_data_q(o_data_q), .o_valid(o_valid),
    .o_complex(o_complex));

// ==== ddc_link_model.sv ====
/*
 * Far side model: link receiver SYNC pin and a DC-coupled SYSREF.
 * Assumes the bench calls its tasks; levels change after an edge.
 */
`timescale 1ns/1ns
module ddc_link_model (
    input  wire logic i_clk,
    output logic      o_sync_n,
    output logic      o_sysref
);
    initial begin
        o_sync_n = 1'b1;
        o_sysref = 1'b0;
    end
    task automatic set_sync(input logic lvl);
        @(posedge i_clk);
        o_sync_n <= lvl;
    endtask
    task automatic set_sysref(input logic lvl);
        @(posedge i_clk);
        o_sysref <= lvl;
    endtask
endmodule

// ==== tb_ddc_nco_sync_decimation.sv ====
/*
 * Self-checking bench for ddc_top with a link and SYSREF model.
 * Assumes 100 MHz clock; stream inputs are DC levels set per mode.
 */
`timescale 1ns/1ns
module tb_ddc_nco_sync_decimation;
    logic               i_clk = 1'b0;
    logic               i_reset = 1'b1;
    logic        [7:0]  i_addr = 8'h00;
    logic        [31:0] i_wdata = 32'h0000_0000;
    logic               i_wr = 1'b0;
    logic               i_rd = 1'b0;
    logic               sync_n, sysref, o_sync_pulse, o_cgs_active;
    logic               ovr0 = 1'b1, ovr1 = 1'b0, o_valid, o_complex;
    logic signed [14:0] mix_i = 15'h03E8, mix_q = 15'h0000;
    logic signed [11:0] real_s = 12'h123;
    logic        [31:0] o_rdata, o_phase_a, o_phase_b, rd_v;
    logic        [15:0] o_data_i, o_data_q;
    int                 miscompares = 0, total_checks = 0, cycles = 0;
    ddc_top uut (
        .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sync_n(sync_n), .i_sysref(sysref), .i_mix_i(mix_i),
        .i_mix_q(mix_q), .i_real(real_s), .i_ovr_zero(ovr0),
        .i_ovr_one(ovr1), .o_phase_a(o_phase_a), .o_phase_b(o_phase_b),
        .o_sync_pulse(o_sync_pulse), .o_cgs_active(o_cgs_active),
        .o_data_i(o_data_i), .o_data_q(o_data_q), .o_valid(o_valid),
        .o_complex(o_complex));
    ddc_link_model peer (.i_clk(i_clk), .o_sync_n(sync_n),
        .o_sysref(sysref));
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            miscompares = miscompares + 1;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_v = o_rdata;
    endtask
    task automatic wait_sync();
        int n;
        n = 0;
        while (o_sync_pulse !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk(o_sync_pulse, 1'b1);
    endtask
    task automatic next_valid(output int g);
        g = 0;
        do begin
            @(posedge i_clk);
            #1 g++;
        end while (o_valid !== 1'b1 && g < 100);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_regs();
        rd(ddc_pkg::CTRL_OFS);
        chk(rd_v, ddc_pkg::CTRL_RST);
        rd(ddc_pkg::STATUS_OFS);
        chk(rd_v, 32'h0000_0000);
        wr(8'hF0, 32'hFFFF_FFFF);
        rd(8'hF0);
        chk(rd_v, 32'h0000_0000);
        wr(ddc_pkg::PHASE_BASE, 32'h0001_ABCD);
        rd(ddc_pkg::PHASE_BASE);
        chk(rd_v, 32'h0000_ABCD);
        $display("test regs done");
    endtask
    task automatic t_offset();
        // Quarter turn on A0, half turn plus one step on B1
        wr(ddc_pkg::PHASE_BASE, 32'h0000_4000);
        wr(8'h34, 32'h0000_8001);
        wr(ddc_pkg::CTRL_OFS, 32'h0000_0400);
        cyc(4);
        chk(o_phase_a, 32'h4000_0000);
        chk(o_phase_b, 32'h8001_0000);
        wr(8'h2C, 32'h0000_1000);
        wr(ddc_pkg::CTRL_OFS, 32'h0000_0700);
        cyc(4);
        chk(o_phase_a, 32'h1000_0000);
        $display("test offset done");
    endtask
    task automatic t_link();
        wr(ddc_pkg::FREQ_BASE, 32'h0000_1234);
        wr(8'h54, 32'h0000_0567);
        rd(8'h54);
        chk(rd_v, 32'h0000_0567);
        rd(ddc_pkg::STATUS_OFS);
        chk(rd_v[ddc_pkg::ST_RESYNC], 1'b1);
        wr(ddc_pkg::CTRL_OFS, 32'h0000_0402);
        peer.set_sync(1'b1);
        wr(ddc_pkg::CTRL_OFS, 32'h0000_0403);
        peer.set_sync(1'b0);
        cyc(8);
        chk(o_cgs_active, 1'b1);
        peer.set_sync(1'b1);
        wait_sync();
        rd(ddc_pkg::STATUS_OFS);
        chk(rd_v[ddc_pkg::ST_RESYNC], 1'b0);
        chk(rd_v[ddc_pkg::ST_CNT_LSB +: 8], 8'h01);
        $display("test link sync done");
    endtask
    task automatic t_enc64();
        wr(ddc_pkg::CTRL_OFS, 32'h0000_040B);
        peer.set_sync(1'b0);
        cyc(8);
        chk(o_cgs_active, 1'b0);
        rd(ddc_pkg::STATUS_OFS);
        chk(rd_v[ddc_pkg::ST_LARM_BIT], 1'b1);
        peer.set_sync(1'b1);
        wait_sync();
        $display("test 64b sync done");
    endtask
    task automatic t_sysref();
        wr(ddc_pkg::CTRL_OFS, 32'h0000_0405);
        rd(ddc_pkg::STATUS_OFS);
        chk(rd_v[ddc_pkg::ST_SARM_BIT], 1'b1);
        peer.set_sysref(1'b1);
        wait_sync();
        peer.set_sysref(1'b0);
        rd(ddc_pkg::CTRL_OFS);
        chk(rd_v[ddc_pkg::ARM_BIT], 1'b0);
        peer.set_sysref(1'b1);
        cyc(10);
        peer.set_sysref(1'b0);
        rd(ddc_pkg::STATUS_OFS);
        chk(rd_v[ddc_pkg::ST_CNT_LSB +: 8], 8'h03);
        wr(ddc_pkg::CTRL_OFS, 32'h0000_0405);
        peer.set_sysref(1'b1);
        wait_sync();
        peer.set_sysref(1'b0);
        $display("test sysref done");
    endtask
    task automatic t_decim();
        int g;
        for (int k = 0; k < 6; k++) begin
            wr(ddc_pkg::CTRL_OFS, 32'(k) << ddc_pkg::DECIM_LSB);
            mix_i  <= 15'(1000 + 50 * k);
            mix_q  <= 15'(-100 * k);
            real_s <= real_s + 12'h111;
            ovr0   <= k[0];
            ovr1   <= !k[0];
            cyc(4);
            if (k == 0 || k == 5) begin
                chk(o_complex, 1'b0);
                chk(o_data_i, {real_s, 4'h0});
            end else begin
                repeat (60) next_valid(g);
                chk(g, 32'd2 << k);
                chk(o_complex, 1'b1);
                chk(o_data_i, {mix_i, ovr0});
                chk(o_data_q, {mix_q, ovr1});
            end
        end
        $display("test decimation done");
    endtask
    initial begin
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        t_regs();
        t_offset();
        t_link();
        t_enc64();
        t_sysref();
        t_decim();
        test_done();
    end
endmodule
